// ==== core/nrt_pkg.sv ====
// package: constants and types for the timekeeping ram
package nrt_pkg;
	localparam int unsigned ADDR_W = 11;
	localparam int unsigned RAM_DEPTH = 2048;
	localparam logic [10:0] REG_CTRL = 11'h7F8;
	localparam logic [10:0] REG_SEC = 11'h7F9;
	localparam logic [10:0] REG_MIN = 11'h7FA;
	localparam logic [10:0] REG_HOUR = 11'h7FB;
	localparam logic [10:0] REG_DAY = 11'h7FC;
	localparam logic [10:0] REG_DATE = 11'h7FD;
	localparam logic [10:0] REG_MON = 11'h7FE;
	localparam logic [10:0] REG_YEAR = 11'h7FF;
	// control register fields
	localparam int unsigned CTRL_LOAD_BIT = 7;
	localparam int unsigned CTRL_READ_BIT = 6;
	localparam int unsigned CENT_MSB = 5;
	localparam logic [5:0] CENT_RST = 6'h20;
	// writable field masks of the clock bytes
	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h3F;
	localparam logic [7:0] MASK_DAY = 8'h07;
	localparam logic [7:0] MASK_DATE = 8'h3F;
	localparam logic [7:0] MASK_MON = 8'h1F;
	localparam logic [7:0] MASK_YEAR = 8'hFF;
	// one second tick from the 100 MHz clock
	localparam longint unsigned SEC_PERIOD_NS = 1000000000;
	localparam longint unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned TICK_CYCLES_DFLT =
		int'(SEC_PERIOD_NS / CLK_PERIOD_NS);
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] mon;
		logic [7:0] date;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} nrt_time_t;
	localparam nrt_time_t TIME_RST = '{year: 8'h00, mon: 8'h01,
		date: 8'h01, day: 8'h01, hour: 8'h00, min: 8'h00, sec: 8'h00};
	typedef struct packed {
		logic [10:0] addr;
		logic [7:0] dq;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic pwr_low;
	} nrt_pins_t;
	localparam nrt_pins_t PINS_IDLE = '{addr: 11'h000, dq: 8'h00,
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, pwr_low: 1'b1};
endpackage

// ==== core/nrt_cal_next.sv ====
// bcd calendar successor of a time value, one second later
`timescale 1ns/1ns
module nrt_cal_next import nrt_pkg::*; (
	input wire nrt_time_t cur_in,
	output nrt_time_t nxt_out
);
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	// leap rule by bcd digits, good up to year 2099
	function automatic logic [7:0] month_last(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		logic [7:0] r;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6) :
			(y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			8'h02: r = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
			default: r = 8'h31;
		endcase
		return r;
	endfunction

	always_comb begin
		nxt_out = cur_in;
		if (cur_in.sec != 8'h59) begin
			nxt_out.sec = bcd_inc(cur_in.sec);
		end else begin
			nxt_out.sec = 8'h00;
			if (cur_in.min != 8'h59) begin
				nxt_out.min = bcd_inc(cur_in.min);
			end else begin
				nxt_out.min = 8'h00;
				if (cur_in.hour != 8'h23) begin // RQ2
					nxt_out.hour = bcd_inc(cur_in.hour);
				end else begin
					nxt_out.hour = 8'h00;
					nxt_out.day = (cur_in.day == 8'h07) ? 8'h01 :
						bcd_inc(cur_in.day);
					if (cur_in.date != month_last(cur_in.mon,
						cur_in.year)) begin // RQ3
						nxt_out.date = bcd_inc(cur_in.date);
					end else begin
						nxt_out.date = 8'h01;
						if (cur_in.mon != 8'h12) begin
							nxt_out.mon = bcd_inc(cur_in.mon);
						end else begin
							nxt_out.mon = 8'h01;
							nxt_out.year = (cur_in.year == 8'h99) ?
								8'h00 : bcd_inc(cur_in.year);
						end
					end
				end
			end
		end
	end
endmodule

// ==== core/nrt_top.sv ====
// timekeeping ram: byte-wide sram bus, ram and bcd clock
//
// Notes on behaviour
// RQ1 - 2k x 8 memory; top eight addresses are clock and control bytes.
// RQ2 - century, date and time kept as bcd, hours in 24-hour form.
// RQ3 - month lengths and leap february handled by the counter itself.
// RQ4 - internal count runs apart from visible bytes; access never stalls it.
// RQ5 - supply low: bus deselected, no reads, no writes, data undriven.
// RQ6 - host should freeze updates before reading the time.
// RQ7 - read-hold bit 6 set stops copies into visible bytes while set.
// RQ8 - while held, visible bytes keep snapshot; internal count keeps going.
// RQ9 - after hold cleared, all visible bytes refresh together within a second.
// RQ10 - host keeps read-hold clear at least 500 us before trusting bytes.
// RQ11 - load-hold bit 7 set halts updates so host can load all bytes.
// RQ12 - writing 00h commits: clear load-hold, load counters, count on.
// RQ13 - clearing read-hold resumes from internal count, no counter load.
// RQ14 - control write setting a hold bit leaves century unchanged.
// RQ15 - control write clearing load-hold writes the century field.
// RQ16 - control write clearing only read-hold keeps the century field.
// RQ17 - chip select high: strobes ignored, data undriven, no access.
// RQ18 - chip select and write strobe low: write, whatever output strobe.
// RQ19 - chip select and output strobe low, write high: drive byte.
// RQ20 - chip select low, output and write strobes high: data undriven.
// RQ21 - host writes zero into unused clock register bits.
// RQ22 - century is two bcd digits, tens in 5:4, units in 3:0.
`timescale 1ns/1ns
module nrt_top import nrt_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [10:0] addr_in,
	input wire logic [7:0] dq_in,
	input wire logic ce_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic below_power_fail_threshold_in,
	output logic [7:0] dq_out,
	output logic dq_oe_out
);
	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	function automatic logic is_clk(input logic [10:0] a);
		return a >= REG_CTRL;
	endfunction

	nrt_pins_t pin_raw;
	nrt_pins_t pin_s1_r;
	nrt_pins_t pin_s2_r;
	logic [7:0] ram_r [0:RAM_DEPTH-1];
	nrt_time_t cnt_r;
	nrt_time_t vis_r;
	nrt_time_t cal_nxt;
	logic [5:0] century_r;
	logic load_hold_r;
	logic read_hold_r;
	logic [31:0] tick_cnt_r;
	logic tick;
	logic wr_act;
	logic rd_act;
	logic wr_prev_r;
	logic wr_go;
	logic [10:0] waddr_r;
	logic [7:0] wdata_r;
	logic ctl_wr;
	logic commit;
	logic [7:0] rd_byte;

	assign pin_raw = '{addr: addr_in, dq: dq_in, ce_n: ce_n_in,
		oe_n: oe_n_in, we_n: we_n_in,
		pwr_low: below_power_fail_threshold_in};

	// pins are asynchronous to ref_clk_in
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			pin_s1_r <= PINS_IDLE;
			pin_s2_r <= PINS_IDLE;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	// RQ17 RQ18 RQ19 RQ20 RQ5
	assign wr_act = !pin_s2_r.ce_n && !pin_s2_r.we_n;
	assign rd_act = !pin_s2_r.ce_n && !pin_s2_r.oe_n && pin_s2_r.we_n &&
		!pin_s2_r.pwr_low;
	// write lands at its end; supply low in that end cycle aborts it
	assign wr_go = wr_prev_r && !wr_act && !pin_s2_r.pwr_low; // RQ5
	assign ctl_wr = wr_go && (waddr_r == REG_CTRL);
	assign commit = ctl_wr && !wdata_r[CTRL_LOAD_BIT] &&
		!wdata_r[CTRL_READ_BIT] && load_hold_r; // RQ12

	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			wr_prev_r <= 1'b0;
			waddr_r <= 11'h000;
			wdata_r <= 8'h00;
		end else begin
			wr_prev_r <= wr_act;
			if (wr_act) begin // RQ18
				waddr_r <= pin_s2_r.addr;
				wdata_r <= pin_s2_r.dq;
			end
		end
	end

	// plain storage below the clock bytes; no reset on the array
	always_ff @(posedge ref_clk_in) begin
		if (wr_go && !is_clk(waddr_r)) begin // RQ1
			ram_r[waddr_r] <= wdata_r;
		end
	end

	// one second tick
	assign tick = (tick_cnt_r == TICK_CYCLES - 1);
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || tick) begin
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
		end
	end

	nrt_cal_next u_cal (
		.cur_in(cnt_r),
		.nxt_out(cal_nxt)
	);

	// internal counters never wait on the bus
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			cnt_r <= TIME_RST;
		end else if (commit) begin
			cnt_r <= vis_r; // RQ12
		end else if (tick) begin
			cnt_r <= cal_nxt; // RQ4 RQ8
		end
	end

	// hold bits and century
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			load_hold_r <= 1'b0;
			read_hold_r <= 1'b0;
			century_r <= CENT_RST;
		end else if (ctl_wr) begin
			load_hold_r <= wdata_r[CTRL_LOAD_BIT]; // RQ11 RQ12
			read_hold_r <= wdata_r[CTRL_READ_BIT]; // RQ7 RQ13
			if (!wdata_r[CTRL_LOAD_BIT] && !wdata_r[CTRL_READ_BIT] &&
				!(read_hold_r && !load_hold_r)) begin // RQ14 RQ16
				century_r <= wdata_r[CENT_MSB:0]; // RQ15 RQ22
			end
		end
	end

	// visible bytes: copied every cycle unless held or a clock or control byte write lands, all at once
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			vis_r <= TIME_RST;
		end else if (wr_go && is_clk(waddr_r) && waddr_r != REG_CTRL) begin
			case (waddr_r)
				REG_SEC: vis_r.sec <= wdata_r & MASK_SEC;
				REG_MIN: vis_r.min <= wdata_r & MASK_MIN;
				REG_HOUR: vis_r.hour <= wdata_r & MASK_HOUR;
				REG_DAY: vis_r.day <= wdata_r & MASK_DAY;
				REG_DATE: vis_r.date <= wdata_r & MASK_DATE;
				REG_MON: vis_r.mon <= wdata_r & MASK_MON;
				default: vis_r.year <= wdata_r & MASK_YEAR;
			endcase
		end else if (!load_hold_r && !read_hold_r && !ctl_wr) begin
			vis_r <= cnt_r; // RQ9 RQ13
		end
	end

	always_comb begin
		case (pin_s2_r.addr)
			REG_CTRL: rd_byte = {load_hold_r, read_hold_r, century_r};
			REG_SEC: rd_byte = vis_r.sec;
			REG_MIN: rd_byte = vis_r.min;
			REG_HOUR: rd_byte = vis_r.hour;
			REG_DAY: rd_byte = vis_r.day;
			REG_DATE: rd_byte = vis_r.date;
			REG_MON: rd_byte = vis_r.mon;
			REG_YEAR: rd_byte = vis_r.year;
			default: rd_byte = ram_r[pin_s2_r.addr];
		endcase
	end

	// data pins
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			dq_out <= 8'h00;
			dq_oe_out <= 1'b0;
		end else begin
			dq_oe_out <= rd_act; // RQ19 RQ20 RQ17 RQ5
			dq_out <= rd_act ? rd_byte : 8'h00;
		end
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);

	property p_pwr_deselect;
		pin_s2_r.pwr_low |=> !dq_oe_out && !$past(wr_go);
	endproperty
	a_pwr_deselect: assert property (p_pwr_deselect) // RQ5
		else $error("bus active while supply low");

	property p_cs_idle;
		pin_s2_r.ce_n |=> !dq_oe_out;
	endproperty
	a_cs_idle: assert property (p_cs_idle) // RQ17
		else $error("data driven with chip select high");

	// write cycles never drive, whatever the output strobe does
	property p_write_no_drive;
		!pin_s2_r.ce_n && !pin_s2_r.we_n |=> !dq_oe_out;
	endproperty
	a_write_no_drive: assert property (p_write_no_drive) // RQ18
		else $error("write cycle drove data");

	property p_write_taken;
		wr_act ##1 (!wr_act && !pin_s2_r.pwr_low) |-> wr_go;
	endproperty
	a_write_taken: assert property (p_write_taken) // RQ18
		else $error("finished write was not taken");

	property p_read_drive;
		rd_act |=> dq_oe_out && dq_out == $past(rd_byte);
	endproperty
	a_read_drive: assert property (p_read_drive) // RQ19
		else $error("read byte not driven");

	property p_read_no_oe;
		!pin_s2_r.ce_n && pin_s2_r.oe_n && pin_s2_r.we_n |=> !dq_oe_out;
	endproperty
	a_read_no_oe: assert property (p_read_no_oe) // RQ20
		else $error("data driven with output strobe high");

	property p_hold_frozen;
		read_hold_r && !wr_go |=> $stable(vis_r);
	endproperty
	a_hold_frozen: assert property (p_hold_frozen) // RQ7
		else $error("visible bytes changed under read hold");

	property p_count_runs;
		tick && !commit |=> cnt_r == $past(cal_nxt);
	endproperty
	a_count_runs: assert property (p_count_runs) // RQ8
		else $error("internal count did not advance");

	property p_refresh;
		!read_hold_r && !load_hold_r && !wr_go |=> vis_r == $past(cnt_r);
	endproperty
	a_refresh: assert property (p_refresh) // RQ9
		else $error("visible bytes not refreshed");

	property p_commit;
		commit |=> cnt_r == $past(vis_r) && !load_hold_r &&
			century_r == $past(wdata_r[CENT_MSB:0]);
	endproperty
	a_commit: assert property (p_commit) // RQ12
		else $error("commit did not load counters and century");

	property p_set_keeps_cent;
		ctl_wr && (wdata_r[CTRL_LOAD_BIT] || wdata_r[CTRL_READ_BIT])
			|=> $stable(century_r);
	endproperty
	a_set_keeps_cent: assert property (p_set_keeps_cent) // RQ14
		else $error("century changed by hold set");

	property p_read_clear_keeps;
		ctl_wr && read_hold_r && !load_hold_r && wdata_r[7:6] == 2'b00
			|=> $stable(century_r) && ($stable(cnt_r) || $past(tick));
	endproperty
	a_read_clear_keeps: assert property (p_read_clear_keeps) // RQ16
		else $error("read hold clear altered century or counters");

	property p_load_frozen;
		load_hold_r && !wr_go |=> $stable(vis_r);
	endproperty
	a_load_frozen: assert property (p_load_frozen) // RQ11
		else $error("visible bytes changed under load hold");

	property p_read_hold_set;
		ctl_wr && wdata_r[CTRL_READ_BIT] |=> read_hold_r;
	endproperty
	a_read_hold_set: assert property (p_read_hold_set) // RQ7
		else $error("read hold bit not set");

	// only a commit may load the counters; a read-hold clear must not
	property p_no_load_on_clear;
		ctl_wr && !load_hold_r && !tick |=> $stable(cnt_r);
	endproperty
	a_no_load_on_clear: assert property (p_no_load_on_clear) // RQ13
		else $error("counters loaded without load hold");

	property p_cent_on_load_clear;
		ctl_wr && load_hold_r && wdata_r[7:6] == 2'b00
			|=> century_r == $past(wdata_r[CENT_MSB:0]);
	endproperty
	a_cent_on_load_clear: assert property (p_cent_on_load_clear) // RQ15
		else $error("century not written when load hold cleared");
endmodule

// ==== tb/nrt_host.sv ====
// host model on the byte-wide sram bus of the timekeeping ram
`timescale 1ns/1ns
module nrt_host import nrt_pkg::*; (
	input wire logic clk_in,
	input wire logic [7:0] dq_in,
	output nrt_pins_t pins_out
);
	int slow = 0;
	initial begin
		pins_out = PINS_IDLE;
		pins_out.pwr_low = 1'b0;
	end
	// every strobe state held 4+ clocks so both pin flops see it
	task automatic hold(input int n);
		repeat (n + slow) @(posedge clk_in);
	endtask
	task automatic pwr(input logic v);
		pins_out.pwr_low <= v;
		hold(4);
	endtask
	task automatic wr(input logic [10:0] a, input logic [7:0] d,
		input logic oe, input logic ce);
		pins_out.addr <= a;
		pins_out.dq <= d;
		pins_out.ce_n <= ce;
		pins_out.oe_n <= oe;
		pins_out.we_n <= 1'b0;
		hold(4);
		// output strobe rises with write so no read follows the write
		pins_out.we_n <= 1'b1;
		pins_out.oe_n <= 1'b1;
		hold(4);
		pins_out.ce_n <= 1'b1;
		pins_out.dq <= ~d;
		hold(4);
	endtask
	task automatic rd(input logic [10:0] a, input logic ce, input logic oe,
		output logic [7:0] q);
		pins_out.addr <= a;
		pins_out.ce_n <= ce;
		pins_out.oe_n <= oe;
		hold(5);
		q = dq_in;
		pins_out.ce_n <= 1'b1;
		pins_out.oe_n <= 1'b1;
		hold(6);
	endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the timekeeping ram
`timescale 1ns/1ns
module tb import nrt_pkg::*; ;
	localparam int TK = 400;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	nrt_pins_t pins;
	logic [7:0] dq_out, got, s0, d;
	logic dq_oe;
	logic oe_q = 1'b0;
	logic [10:0] a;
	logic [15:0] expq[$];
	logic [15:0] e;
	// year, month, date loaded, then expected one second later
	logic [47:0] cal [4] = '{48'h240228240229, 48'h230228230301,
		48'h240430240501, 48'h241231250101};
	int fails = 0;
	int check_count = 0;
	int seed = 32'hF8B1;
	always #5 ref_clk = ~ref_clk;
	nrt_host host_i (.clk_in(ref_clk), .dq_in(dq_out), .pins_out(pins));
	nrt_top #(.TICK_CYCLES(TK)) nrt_top_i (.ref_clk_in(ref_clk),
		.srst_in(srst), .addr_in(pins.addr), .dq_in(pins.dq),
		.ce_n_in(pins.ce_n), .oe_n_in(pins.oe_n), .we_n_in(pins.we_n),
		.below_power_fail_threshold_in(pins.pwr_low), .dq_out(dq_out),
		.dq_oe_out(dq_oe));
	task automatic chk(input logic [7:0] m, input logic [7:0] x,
		input logic [7:0] g);
		check_count++;
		if ((g & m) !== x) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g & m, x);
		end
	endtask
	task automatic rd(input logic [10:0] ad, input logic [7:0] m,
		input logic [7:0] x);
		expq.push_back({m, x});
		host_i.rd(ad, 1'b0, 1'b0, got);
		chk(8'hFF, 8'h00, 8'(expq.size()));
	endtask
	task automatic cw(input logic [10:0] ad, input logic [7:0] x);
		host_i.wr(ad, x, 1'b1, 1'b0);
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// a drive with nothing queued always fails
	always @(posedge ref_clk) begin
		oe_q <= dq_oe;
		if (dq_oe === 1'b1 && oe_q !== 1'b1) begin
			if (expq.size() == 0)
				chk(8'h00, 8'h01, dq_out);
			else begin
				e = expq.pop_front();
				chk(e[15:8], e[7:0], dq_out);
			end
		end
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		fails++;
		close_out;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(REG_CTRL, 8'hFF, 8'h20);
		rd(REG_DATE, 8'hFF, 8'h01);
		for (int i = 0; i < 4; i++) begin
			a = i == 0 ? 11'h7F7 : {1'b0, 10'($random(seed))};
			d = 8'($random(seed));
			host_i.slow = i % 2;
			host_i.wr(a, d, i[0], 1'b0);
			host_i.wr(a, ~d, 1'b0, 1'b1);
			rd(a, 8'hFF, d);
			host_i.rd(a, 1'b1, 1'b0, got);
			host_i.rd(a, 1'b0, 1'b1, got);
		end
		host_i.pwr(1'b1);
		host_i.wr(a, ~d, 1'b1, 1'b0);
		host_i.rd(a, 1'b0, 1'b0, got);
		host_i.pwr(1'b0);
		rd(a, 8'hFF, d);
		foreach (cal[k]) begin
			cw(REG_CTRL, 8'h80);
			cw(REG_SEC, 8'h59);
			cw(REG_MIN, 8'h59);
			cw(REG_HOUR, 8'h23);
			cw(REG_DAY, 8'h07);
			cw(REG_DATE, cal[k][31:24]);
			cw(REG_MON, cal[k][39:32]);
			cw(REG_YEAR, cal[k][47:40]);
			cw(REG_CTRL, 8'h21);
			// two or three ticks pass, never a full minute
			repeat (2 * TK) @(posedge ref_clk);
			cw(REG_CTRL, 8'h7F);
			rd(REG_YEAR, 8'hFF, cal[k][23:16]);
			rd(REG_MON, 8'hFF, cal[k][15:8]);
			rd(REG_DATE, 8'hFF, cal[k][7:0]);
			rd(REG_DAY, 8'hFF, 8'h01);
			rd(REG_HOUR, 8'hFF, 8'h00);
			rd(REG_SEC, 8'hF0, 8'h00);
			rd(REG_CTRL, 8'hFF, 8'h61);
			cw(REG_CTRL, 8'h00);
			rd(REG_CTRL, 8'hFF, 8'h21);
		end
		cw(REG_CTRL, 8'h40);
		rd(REG_SEC, 8'h00, 8'h00);
		s0 = got;
		repeat (3 * TK) @(posedge ref_clk);
		rd(REG_SEC, 8'hFF, s0);
		cw(REG_CTRL, 8'h00);
		repeat (3 * TK) @(posedge ref_clk);
		rd(REG_SEC, 8'h00, 8'h00);
		chk(8'hFF, 8'h01, 8'(got !== s0));
		close_out;
	end
endmodule
